// ===== cpucr_regfile.sv
// CPU core dedicated registers, flags and memory address forming
`timescale 1ns/1ns
module cpucr_regfile
    import cpucr_pkg::*;
#(
    parameter logic [15:0] BANK_BASE = `CPUCR_BANK_BASE
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic        dp_ld,
    input  wire logic [2:0]  dp_sel,
    input  wire logic [15:0] dp_data,
    input  wire logic        fetch_adv,
    input  wire logic        alu_go,
    input  wire logic        alu_sub,
    input  wire logic        alu_byte,
    input  wire logic [15:0] alu_a,
    input  wire logic [15:0] alu_b,
    input  wire logic        shf_go,
    input  wire logic        shf_out,
    input  wire logic [15:0] shf_res,
    input  wire logic        irq_req,
    input  wire logic [1:0]  irq_lvl,
    output logic             irq_take,
    input  wire logic        dir_go,
    input  wire logic [7:0]  dir_addr,
    output logic      [15:0] dir_mem_addr,
    input  wire logic        gpr_go,
    input  wire logic [7:0]  gpr_opc,
    output logic      [15:0] gpr_mem_addr,
    output logic      [15:0] fetch_location,
    output logic      [15:0] work_result_word,
    output logic      [15:0] second_operand_reg,
    output logic      [15:0] index_reg,
    output logic      [15:0] extra_pointer_reg,
    output logic      [15:0] stack_top_reg,
    output logic      [15:0] processor_state_word
);
    // ============================================================
    // Storage
    cpucr_word_t regs_ff [`CPUCR_NREG];
    logic [15:0] rdata_ff;
    logic        irq_take_ff;
    logic [15:0] dir_mem_ff;
    logic [15:0] gpr_mem_ff;
    logic        first_ff;

    function automatic cpucr_word_t rst_val(input int idx);
        if (idx == int'(`CPUCR_OFS_PC)) begin
            return `CPUCR_RST_PC;
        end
        if (idx == int'(`CPUCR_OFS_PS)) begin
            return `CPUCR_RST_PS;
        end
        return `CPUCR_RST_GN;
    endfunction

    function automatic logic ovf(input logic sa, input logic sb,
                                 input logic sr, input logic sub);
        ovf = sub ? ((sa != sb) && (sr != sa)) : ((sa == sb) && (sr != sa));
    endfunction

    function automatic logic is_reg(input logic [3:0] adr);
        is_reg = !adr[3] && (adr[2:0] < 3'(`CPUCR_NREG));
    endfunction

    // ============================================================
    // Arithmetic flag formation
    logic [4:0]  nib5;
    logic [8:0]  lo9;
    logic [16:0] w17;
    logic [15:0] res_used;
    logic        f_h;
    logic        f_n;
    logic        f_z;
    logic        f_v;
    logic        f_c;

    always_comb begin
        if (alu_sub) begin
            nib5 = {1'b0, alu_a[3:0]} - {1'b0, alu_b[3:0]};
            lo9  = {1'b0, alu_a[7:0]} - {1'b0, alu_b[7:0]};
            w17  = {1'b0, alu_a} - {1'b0, alu_b};
        end else begin
            nib5 = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]};
            lo9  = {1'b0, alu_a[7:0]} + {1'b0, alu_b[7:0]};
            w17  = {1'b0, alu_a} + {1'b0, alu_b};
        end
    end

    // Byte ops keep the upper accumulator byte untouched
    assign res_used = alu_byte ? {8'h00, lo9[7:0]} : w17[15:0];
    assign f_h = nib5[4];
    assign f_n = alu_byte ? lo9[7] : w17[15];
    assign f_z = (res_used == 16'h0000);
    assign f_v = alu_byte
        ? ovf(alu_a[7], alu_b[7], lo9[7], alu_sub)
        : ovf(alu_a[15], alu_b[15], w17[15], alu_sub);
    assign f_c = alu_byte ? lo9[8] : w17[16];

    // ============================================================
    // Dedicated registers
    logic [2:0] wsel;
    logic       bus_wr;
    assign wsel   = reg_addr[2:0];
    assign bus_wr = reg_wr && is_reg(reg_addr);

    // Later statements win: a flag event in the same cycle as a
    // software write to the state word is kept, never dropped
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `CPUCR_NREG; i++) begin
                regs_ff[i] <= rst_val(i);
            end
        end else if (clk_en) begin
            if (fetch_adv) begin
                regs_ff[`CPUCR_OFS_PC] <= regs_ff[`CPUCR_OFS_PC] + 16'h0001;
            end
            if (bus_wr) begin
                regs_ff[wsel] <= reg_wdata;
            end
            if (dp_ld && (dp_sel < 3'(`CPUCR_NREG))) begin
                regs_ff[dp_sel] <= dp_data;
            end
            if (alu_go) begin
                regs_ff[`CPUCR_OFS_A] <= alu_byte
                    ? {regs_ff[`CPUCR_OFS_A][15:8], lo9[7:0]}
                    : w17[15:0];
                regs_ff[`CPUCR_OFS_PS][`CPUCR_PS_H] <= f_h;
                regs_ff[`CPUCR_OFS_PS][`CPUCR_PS_N] <= f_n;
                regs_ff[`CPUCR_OFS_PS][`CPUCR_PS_Z] <= f_z;
                regs_ff[`CPUCR_OFS_PS][`CPUCR_PS_V] <= f_v;
                regs_ff[`CPUCR_OFS_PS][`CPUCR_PS_C] <= f_c;
            end
            if (shf_go) begin
                regs_ff[`CPUCR_OFS_A] <= shf_res;
                regs_ff[`CPUCR_OFS_PS][`CPUCR_PS_C] <= shf_out;
            end
        end
    end

    // ============================================================
    // State word fields
    logic [4:0] bank_select_field;
    logic [2:0] direct_page_field;
    logic [7:0] condition_flags;
    logic [1:0] current_level_field;
    logic       irq_gate;

    assign bank_select_field =
        regs_ff[`CPUCR_OFS_PS][`CPUCR_PS_RPH:`CPUCR_PS_RPL];
    assign direct_page_field =
        regs_ff[`CPUCR_OFS_PS][`CPUCR_PS_DPH:`CPUCR_PS_DPL];
    assign condition_flags = regs_ff[`CPUCR_OFS_PS][7:0];
    assign current_level_field =
        condition_flags[`CPUCR_PS_ILH:`CPUCR_PS_ILL];
    assign irq_gate = condition_flags[`CPUCR_PS_I];

    // ============================================================
    // Software read port
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 16'h0000;
        end else if (clk_en) begin
            if (reg_rd && is_reg(reg_addr)) begin
                rdata_ff <= regs_ff[wsel];
            end else begin
                rdata_ff <= 16'h0000;
            end
        end
    end

    // ============================================================
    // Interrupt acceptance
    // Level 0 blocks all: no request level compares below it
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_take_ff <= 1'b0;
        end else if (clk_en) begin
            irq_take_ff <= irq_req && irq_gate
                           && (irq_lvl < current_level_field);
        end
    end

    // ============================================================
    // Memory address forming
    cpucr_map_if mif ();
    assign mif.direct_page_field = direct_page_field;
    assign mif.bank_select_field = bank_select_field;
    assign mif.dir_addr          = dir_addr;
    assign mif.slot              = gpr_opc[2:0];

    cpucr_addr_map #(
        .BANK_BASE (BANK_BASE)
    ) u_map (
        .m (mif.mapr)
    );

    // 16-bit results: direct addresses stay within 0000-047F, bank addresses within BANK_BASE to BANK_BASE+00FF
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dir_mem_ff <= 16'h0000;
            gpr_mem_ff <= 16'h0000;
        end else if (clk_en) begin
            if (dir_go) begin
                dir_mem_ff <= mif.dir_mem;
            end
            if (gpr_go) begin
                gpr_mem_ff <= mif.bank_mem;
            end
        end
    end

    // ============================================================
    // Outputs
    assign reg_rdata            = rdata_ff;
    assign irq_take             = irq_take_ff;
    assign dir_mem_addr         = dir_mem_ff;
    assign gpr_mem_addr         = gpr_mem_ff;
    assign fetch_location       = regs_ff[`CPUCR_OFS_PC];
    assign work_result_word     = regs_ff[`CPUCR_OFS_A];
    assign second_operand_reg   = regs_ff[`CPUCR_OFS_T];
    assign index_reg            = regs_ff[`CPUCR_OFS_IX];
    assign extra_pointer_reg    = regs_ff[`CPUCR_OFS_EP];
    assign stack_top_reg        = regs_ff[`CPUCR_OFS_SP];
    assign processor_state_word = regs_ff[`CPUCR_OFS_PS];

    // ============================================================
    // Checks
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            first_ff <= 1'b1;
        end else if (clk_en) begin
            first_ff <= 1'b0;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_reset_vals;
        first_ff |-> fetch_location == `CPUCR_RST_PC
            && processor_state_word == `CPUCR_RST_PS
            && work_result_word == `CPUCR_RST_GN
            && stack_top_reg == `CPUCR_RST_GN;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("reset values wrong");

    property p_nib;
        clk_en && alu_go && !shf_go |=>
            processor_state_word[`CPUCR_PS_H] == $past(nib5[4]);
    endproperty
    a_nib: assert property (p_nib)
        else $error("nibble carry flag wrong");

    property p_sign_zero;
        clk_en && alu_go && !shf_go |=>
            processor_state_word[`CPUCR_PS_N] ==
                ($past(alu_byte) ? $past(lo9[7]) : $past(w17[15]))
            && processor_state_word[`CPUCR_PS_Z] ==
                ($past(res_used) == 16'h0000);
    endproperty
    a_sign_zero: assert property (p_sign_zero)
        else $error("sign or zero flag wrong");

    property p_wrap;
        clk_en && alu_go && !shf_go && !alu_sub && alu_byte
            && alu_a[7:0] == 8'h7f && alu_b[7:0] == 8'h01 |=>
            processor_state_word[`CPUCR_PS_V]
            && !processor_state_word[`CPUCR_PS_C];
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("signed wrap flag not set");

    property p_shift_c;
        clk_en && shf_go |=>
            processor_state_word[`CPUCR_PS_C] == $past(shf_out);
    endproperty
    a_shift_c: assert property (p_shift_c)
        else $error("shift carry wrong");

    property p_irq_gate;
        clk_en && !irq_gate |=> !irq_take;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt taken while gated");

    property p_irq_lvl;
        clk_en && irq_req && irq_gate |=>
            irq_take == ($past(irq_lvl) < $past(current_level_field));
    endproperty
    a_irq_lvl: assert property (p_irq_lvl)
        else $error("interrupt level compare wrong");

    property p_dir_pass;
        clk_en && dir_go && !dir_addr[7] |=>
            dir_mem_addr == {8'h00, $past(dir_addr)};
    endproperty
    a_dir_pass: assert property (p_dir_pass)
        else $error("low direct address remapped");

    property p_dir_map;
        clk_en && dir_go && dir_addr[7] && direct_page_field == 3'h7 |=>
            dir_mem_addr == {9'h008, $past(dir_addr[6:0])};
    endproperty
    a_dir_map: assert property (p_dir_map)
        else $error("direct page remap wrong");

    property p_gpr;
        clk_en && gpr_go |=>
            gpr_mem_addr[2:0] == $past(gpr_opc[2:0])
            && gpr_mem_addr == BANK_BASE
                + {8'h00, $past(bank_select_field), 3'h0}
                + {13'h0000, $past(gpr_opc[2:0])};
    endproperty
    a_gpr: assert property (p_gpr)
        else $error("bank address wrong");
endmodule

// ===== cpucr_cfg.svh
// Constants of the CPU core register set
//
// Functional notes
// - Reset loads fetch FFFD, state word 0030, all other registers zero.
// - Work result and second operand are 16 bits; byte ops use low byte.
// - Fetch, index, extra pointer and stack top are 16-bit registers.
// - State word: high byte bank and page fields, low byte condition flags.
// - Direct 0080-00FF moves up by 80 hex per page value step.
// - Direct 0000-007F passes unchanged whatever the page field holds.
// - Nibble carry flag set on carry or borrow from bit 3 to 4.
// - Interrupt gate flag one accepts, zero blocks; reset clears it.
// - Request serviced only if its level beats the current level field.
// - Sign copy flag follows the most significant result bit.
// - Zero result flag set when result is zero, else cleared.
// - Signed wrap flag set on two's complement overflow, else cleared.
// - Carry-out flag from bit 7 on byte ops, bit 15 on word ops; shifts load the shifted-out bit.
// - Byte registers sit in memory, eight per bank, 32 banks selectable.
// - Low three opcode bits pick the register within the current bank.
// - Addresses span a 64-kilobyte space holding banks and vectors.
`ifndef CPUCR_CFG_SVH
`define CPUCR_CFG_SVH
// ============================================================
// Register offsets on the software port
`define CPUCR_OFS_PC 3'h0
`define CPUCR_OFS_A  3'h1
`define CPUCR_OFS_T  3'h2
`define CPUCR_OFS_IX 3'h3
`define CPUCR_OFS_EP 3'h4
`define CPUCR_OFS_SP 3'h5
`define CPUCR_OFS_PS 3'h6
`define CPUCR_NREG   7
// ============================================================
// Reset values
`define CPUCR_RST_PC 16'hfffd
`define CPUCR_RST_PS 16'h0030
`define CPUCR_RST_GN 16'h0000
// ============================================================
// State word fields
`define CPUCR_PS_C   0
`define CPUCR_PS_V   1
`define CPUCR_PS_Z   2
`define CPUCR_PS_N   3
`define CPUCR_PS_ILL 4
`define CPUCR_PS_ILH 5
`define CPUCR_PS_I   6
`define CPUCR_PS_H   7
`define CPUCR_PS_DPL 8
`define CPUCR_PS_DPH 10
`define CPUCR_PS_RPL 11
`define CPUCR_PS_RPH 15
// ============================================================
// Address map
`define CPUCR_DIR_WIN   16'h0080
`define CPUCR_BANK_BASE 16'h0100
`endif

// ===== cpucr_pkg.sv
// Types shared by the CPU core register set
package cpucr_pkg;
`include "cpucr_cfg.svh"
    typedef logic [15:0] cpucr_word_t;
    typedef enum logic [2:0] {
        CPUCR_R_PC = `CPUCR_OFS_PC,
        CPUCR_R_A  = `CPUCR_OFS_A,
        CPUCR_R_T  = `CPUCR_OFS_T,
        CPUCR_R_IX = `CPUCR_OFS_IX,
        CPUCR_R_EP = `CPUCR_OFS_EP,
        CPUCR_R_SP = `CPUCR_OFS_SP,
        CPUCR_R_PS = `CPUCR_OFS_PS
    } cpucr_reg_e;
endpackage

// ===== cpucr_map_if.sv
// Carrier between the register set and its address mapper
`timescale 1ns/1ns
interface cpucr_map_if;
    logic [2:0]  direct_page_field;
    logic [4:0]  bank_select_field;
    logic [7:0]  dir_addr;
    logic [2:0]  slot;
    logic [15:0] dir_mem;
    logic [15:0] bank_mem;
    modport core (output direct_page_field, bank_select_field, dir_addr,
                  slot, input dir_mem, bank_mem);
    modport mapr (input direct_page_field, bank_select_field, dir_addr,
                  slot, output dir_mem, bank_mem);
endinterface

// ===== cpucr_addr_map.sv
// Direct page remap and register bank address forming
`timescale 1ns/1ns
module cpucr_addr_map
    import cpucr_pkg::*;
#(
    parameter logic [15:0] BANK_BASE = `CPUCR_BANK_BASE
) (
    cpucr_map_if.mapr m
);
    // ============================================================
    // Direct addressing
    always_comb begin
        if (!m.dir_addr[7]) begin
            m.dir_mem = {8'h00, m.dir_addr};
        end else begin
            m.dir_mem = `CPUCR_DIR_WIN + {6'h00, m.direct_page_field, 7'h00}
                        + {9'h000, m.dir_addr[6:0]};
        end
    end

    // ============================================================
    // Bank slots
    // Slot bits fill the low three bits, so no adder carry from them
    assign m.bank_mem = BANK_BASE
        + {8'h00, m.bank_select_field, m.slot};
endmodule

// ===== cpucr_core_model.sv
// Stand-in for the decoder, datapath and memory bus beside the register set
`timescale 1ns/1ns
module cpucr_core_model
    import cpucr_pkg::*;
(
    input  wire logic        core_clk,
    output logic             dp_ld,
    output logic      [2:0]  dp_sel,
    output cpucr_word_t      dp_data,
    output logic             fetch_adv,
    output logic             alu_go,
    output logic             alu_sub,
    output logic             alu_byte,
    output cpucr_word_t      alu_a,
    output cpucr_word_t      alu_b,
    output logic             shf_go,
    output logic             shf_out,
    output cpucr_word_t      shf_res,
    output logic             irq_req,
    output logic      [1:0]  irq_lvl,
    output logic             dir_go,
    output logic      [7:0]  dir_addr,
    output logic             gpr_go,
    output logic      [7:0]  gpr_opc
);
    initial begin
        {dp_ld, dp_sel, dp_data, fetch_adv, alu_go, alu_sub, alu_byte} = '0;
        {alu_a, alu_b, shf_go, shf_out, shf_res, irq_req, irq_lvl} = '0;
        {dir_go, dir_addr, gpr_go, gpr_opc} = '0;
    end
    // ============================================================
    // Command tasks
    // alu_a, alu_b, dp_data and shf_res are inverted on release so a stale value is never reused
    task automatic finish;
        @(posedge core_clk);
        {dp_ld, fetch_adv, alu_go, shf_go, dir_go, gpr_go} <= '0;
        {alu_a, alu_b, dp_data, shf_res} <= ~{alu_a, alu_b, dp_data, shf_res};
        #1;
    endtask
    task automatic alu(input logic s, input logic y, input cpucr_word_t a,
                       input cpucr_word_t b);
        @(posedge core_clk);
        {alu_go, alu_sub, alu_byte, alu_a, alu_b} <= {1'b1, s, y, a, b};
        finish();
    endtask
    task automatic shf(input logic o, input cpucr_word_t r);
        @(posedge core_clk);
        {shf_go, shf_out, shf_res} <= {1'b1, o, r};
        finish();
    endtask
    task automatic load(input logic [2:0] s, input cpucr_word_t d);
        @(posedge core_clk);
        {dp_ld, dp_sel, dp_data} <= {1'b1, s, d};
        finish();
    endtask
    task automatic adv;
        @(posedge core_clk);
        fetch_adv <= 1'b1;
        finish();
    endtask
    task automatic dir(input logic [7:0] a);
        @(posedge core_clk);
        {dir_go, dir_addr} <= {1'b1, a};
        finish();
    endtask
    task automatic gpr(input logic [7:0] o);
        @(posedge core_clk);
        {gpr_go, gpr_opc} <= {1'b1, o};
        finish();
    endtask
    task automatic irq(input logic r, input logic [1:0] l);
        @(posedge core_clk);
        {irq_req, irq_lvl} <= {r, l};
        finish();
    endtask
endmodule

// ===== cpucr_regfile_tb.sv
// Self-checking bench for the CPU core register set
`timescale 1ns/1ns
module cpucr_regfile_tb
    import cpucr_pkg::*;
;
    localparam cpucr_word_t BB = 16'h0100;
    logic        core_clk, rst_n, clk_en, reg_wr, reg_rd, irq_take;
    logic        dp_ld, fetch_adv, alu_go, alu_sub, alu_byte, shf_go;
    logic        shf_out, irq_req, dir_go, gpr_go, s, y;
    logic [3:0]  reg_addr;
    logic [2:0]  dp_sel;
    logic [1:0]  irq_lvl;
    logic [7:0]  dir_addr, gpr_opc;
    cpucr_word_t reg_wdata, reg_rdata, dir_mem_addr, gpr_mem_addr, dp_data;
    cpucr_word_t alu_a, alu_b, shf_res, v, ps, av, a, b;
    cpucr_word_t fetch_location, work_result_word, second_operand_reg;
    cpucr_word_t index_reg, extra_pointer_reg, stack_top_reg;
    cpucr_word_t processor_state_word;
    int          fails, check_count;
    cpucr_word_t rst_tab [7] = '{16'hfffd, 16'h0000, 16'h0000, 16'h0000,
                                 16'h0000, 16'h0000, 16'h0030};
    // Sub, byte, a, b: word adds 7fff+1 and ffff+1 repeat the flag mixes of byte adds 7f+1 and ff+1
    logic [33:0] alu_tab [8] = '{{2'b01, 16'h3c0f, 16'h0001},
        {2'b01, 16'h007f, 16'h0001}, {2'b01, 16'h00ff, 16'h0001},
        {2'b11, 16'h0000, 16'h0001}, {2'b11, 16'h0080, 16'h0001},
        {2'b00, 16'h7fff, 16'h0001}, {2'b00, 16'hffff, 16'h0001},
        {2'b10, 16'h1234, 16'h1234}};

    cpucr_regfile #(.BANK_BASE(BB)) dut (
        .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dp_ld(dp_ld),
        .dp_sel(dp_sel), .dp_data(dp_data), .fetch_adv(fetch_adv),
        .alu_go(alu_go), .alu_sub(alu_sub), .alu_byte(alu_byte),
        .alu_a(alu_a), .alu_b(alu_b), .shf_go(shf_go), .shf_out(shf_out),
        .shf_res(shf_res), .irq_req(irq_req), .irq_lvl(irq_lvl),
        .irq_take(irq_take), .dir_go(dir_go), .dir_addr(dir_addr),
        .dir_mem_addr(dir_mem_addr), .gpr_go(gpr_go), .gpr_opc(gpr_opc),
        .gpr_mem_addr(gpr_mem_addr), .fetch_location(fetch_location),
        .work_result_word(work_result_word),
        .second_operand_reg(second_operand_reg), .index_reg(index_reg),
        .extra_pointer_reg(extra_pointer_reg), .stack_top_reg(stack_top_reg),
        .processor_state_word(processor_state_word));
    cpucr_core_model m (
        .core_clk(core_clk), .dp_ld(dp_ld), .dp_sel(dp_sel),
        .dp_data(dp_data), .fetch_adv(fetch_adv), .alu_go(alu_go),
        .alu_sub(alu_sub), .alu_byte(alu_byte), .alu_a(alu_a),
        .alu_b(alu_b), .shf_go(shf_go), .shf_out(shf_out),
        .shf_res(shf_res), .irq_req(irq_req), .irq_lvl(irq_lvl),
        .dir_go(dir_go), .dir_addr(dir_addr), .gpr_go(gpr_go),
        .gpr_opc(gpr_opc));

    initial core_clk = 1'b0;
    always #50 core_clk = ~core_clk;
    // ============================================================
    // Bus tasks, checking and verdict
    task automatic chk(input cpucr_word_t got, input cpucr_word_t exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] ad, input cpucr_word_t d);
        @(posedge core_clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, ad, d};
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rc(input logic [3:0] ad, input cpucr_word_t exp);
        @(posedge core_clk);
        {reg_rd, reg_addr} <= {1'b1, ad};
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Reference flag update; acc holds the old and returns the new result
    function automatic cpucr_word_t ref_ps(input cpucr_word_t p,
        input logic sb, input logic by, input cpucr_word_t x,
        input cpucr_word_t z, inout cpucr_word_t acc);
        logic [16:0] r;
        logic [4:0]  h;
        cpucr_word_t xw, zw;
        xw = by ? {x[7:0], 8'h00} : x;
        zw = by ? {z[7:0], 8'h00} : z;
        r = sb ? {1'b0, xw} - {1'b0, zw} : {1'b0, xw} + {1'b0, zw};
        h = sb ? {1'b0, x[3:0]} - {1'b0, z[3:0]}
               : {1'b0, x[3:0]} + {1'b0, z[3:0]};
        acc = by ? {acc[15:8], r[15:8]} : r[15:0];
        p[7] = h[4];
        p[3] = r[15];
        p[2] = (r[15:0] == 16'h0000);
        p[1] = (xw[15] == (zw[15] ^ sb)) && (r[15] != xw[15]);
        p[0] = r[16];
        return p;
    endfunction

    initial begin
        #1_000_000;
        fails++;
        stop_test();
    end
    // ============================================================
    // Main sequence
    initial begin
        {rst_n, clk_en, reg_wr, reg_rd, reg_addr, reg_wdata} = 24'h400000;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        chk(processor_state_word, 16'h0030);
        for (int i = 0; i < 7; i++) rc(i[3:0], rst_tab[i]);
        for (int i = 0; i < 7; i++) begin
            wr(i[3:0], 16'h1111 * 16'(i + 1) ^ 16'h8000);
        end
        for (int i = 0; i < 7; i++) begin
            rc(i[3:0], 16'h1111 * 16'(i + 1) ^ 16'h8000);
        end
        @(posedge core_clk);
        #1 chk(reg_rdata, 16'h0000);
        chk(second_operand_reg, 16'hb333);
        chk(index_reg, 16'hc444);
        chk(stack_top_reg, 16'he666);
        wr(4'hf, 16'hffff);
        rc(4'hf, 16'h0000);
        rc(4'h1, 16'ha222);
        for (int dp = 0; dp < 8; dp++) begin
            wr(4'h6, {5'h00, dp[2:0], 8'h00});
            m.dir(8'h85);
            chk(dir_mem_addr, 16'h0085 + 16'(dp) * 16'h0080);
            m.dir(8'h7f);
            chk(dir_mem_addr, 16'h007f);
        end
        for (int bk = 0; bk < 32; bk++) begin
            wr(4'h6, {bk[4:0], 11'h000});
            m.gpr({~bk[4:0], bk[2:0]});
            v = BB + 16'(bk) * 16'h0008 + 16'(bk[2:0]);
            chk(gpr_mem_addr, v);
        end
        for (int il = 0; il < 4; il++) begin
            for (int lv = 0; lv < 4; lv++) begin
                wr(4'h6, {8'h00, 2'b01, il[1:0], 4'h0});
                m.irq(1'b1, lv[1:0]);
                chk({15'h0, irq_take}, {15'h0, lv < il});
            end
        end
        m.irq(1'b0, 2'd0);
        chk({15'h0, irq_take}, 16'h0000);
        wr(4'h6, 16'h0030);
        m.irq(1'b1, 2'd0);
        chk({15'h0, irq_take}, 16'h0000);
        wr(4'h6, 16'h0000);
        wr(4'h1, 16'hc300);
        {ps, av} = {16'h0000, 16'hc300};
        for (int i = 0; i < 8; i++) begin
            {s, y, a, b} = alu_tab[i];
            ps = ref_ps(ps, s, y, a, b, av);
            m.alu(s, y, a, b);
            chk(work_result_word, av);
            rc(4'h6, ps);
        end
        m.shf(1'b1, 16'h8001);
        chk(work_result_word, 16'h8001);
        chk({15'h0, processor_state_word[0]}, 16'h0001);
        m.shf(1'b0, 16'h0002);
        chk({15'h0, processor_state_word[0]}, 16'h0000);
        wr(4'h0, 16'hffff);
        m.adv();
        chk(fetch_location, 16'h0000);
        @(posedge core_clk);
        clk_en <= 1'b0;
        m.adv();
        chk(fetch_location, 16'h0000);
        @(posedge core_clk);
        clk_en <= 1'b1;
        m.load(3'h4, 16'hbeef);
        chk(extra_pointer_reg, 16'hbeef);
        @(posedge core_clk);
        rst_n <= 1'b0;
        #20 chk(fetch_location, 16'hfffd);
        chk(extra_pointer_reg, 16'h0000);
        chk(processor_state_word, 16'h0030);
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        rc(4'h1, 16'h0000);
        stop_test();
    end
endmodule
